// file: tccr_pkg.sv
/*
  tccr_pkg: register map, field positions, reset values and mode codes of the
  timer / PWM block with per-channel status and control.
  Assumes a classic Wishbone slave with 32-bit data and byte registers in bits 7:0.
*/
package tccr_pkg;
  localparam int         ADR_W       = 8;
  // register byte addresses
  localparam logic [7:0] OFF_TSC     = 8'h00;
  localparam logic [7:0] OFF_CNTH    = 8'h04;
  localparam logic [7:0] OFF_CNTL    = 8'h08;
  localparam logic [7:0] OFF_MODH    = 8'h0C;
  localparam logic [7:0] OFF_MODL    = 8'h10;
  localparam logic [7:0] CH_BASE     = 8'h20;
  localparam logic [7:0] CH_STRIDE   = 8'h10;
  localparam logic [7:0] CH_SC       = 8'h00;
  localparam logic [7:0] CH_VH       = 8'h04;
  localparam logic [7:0] CH_VL       = 8'h08;
  // timer_status_control fields
  localparam int         TSC_TOF     = 7;
  localparam int         TSC_TOIE    = 6;
  localparam int         TSC_CPWM    = 5;
  localparam int         TSC_CLK_LSB = 3;
  localparam int         TSC_PS_LSB  = 0;
  // channel_status_control fields
  localparam int         SC_FLAG     = 7;
  localparam int         SC_IE       = 6;
  localparam int         SC_MSH      = 5;
  localparam int         SC_MSL      = 4;
  localparam int         SC_ELS_LSB  = 2;
  // clock_source_select codes
  localparam logic [1:0] CLK_OFF     = 2'h0;
  localparam logic [1:0] CLK_BUS     = 2'h1;
  localparam logic [1:0] CLK_FIXED   = 2'h2;
  localparam logic [1:0] CLK_EXT     = 2'h3;
  // edge_level_select codes
  localparam logic [1:0] ELS_NONE    = 2'h0;
  localparam logic [1:0] ELS_01      = 2'h1;
  localparam logic [1:0] ELS_10      = 2'h2;
  localparam logic [1:0] ELS_11      = 2'h3;
  // reset values and the full-range count
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] MOD_RST    = 16'h0000;
  localparam logic [15:0] CNT_FULL   = 16'hFFFF;
  localparam logic [15:0] VAL_RST    = 16'h0000;
  localparam logic [6:0]  PS_RST     = 7'h00;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } tccr_mode_t;
endpackage

// file: tccr_top.sv
/*
  tccr_top: 16-bit timer with prescaler, modulo, coherent counter reads and a
  parameterised set of capture / compare / PWM channels, behind classic Wishbone.
  Assumes all inputs synchronous to clk; fixedClkTick and extClkIn already
  synchronised; debugMode high while the processor sits in background debug.
*/
// How it works
// - clock source code picks off, bus clock, fixed clock or external input
// - prescaler divides the chosen clock by two to the power prescale_select
// - reading a counter byte snapshots both bytes until the other is read
// - snapshot released by reset, counter byte writes or status/control writes
// - counter resets to zero and cannot be loaded by software
// - debug mode freezes the counter and the snapshot state
// - at modulo the overflow flag sets; counter restarts or turns downward
// - after one modulo byte write, overflow flag waits for the other byte
// - modulo resets to zero meaning a free run over the full range
// - capture mode sets the channel flag on the selected pin edge
// - compare and edge PWM set the channel flag on counter match
// - center PWM sets the channel flag on matches both up and down
// - channel interrupt asserts while flag and enable are both set
// - flag clears only by read-while-set then write 0; reset clears it
// - a new event between read and write cancels the clear
// - channel interrupt enable is read/write and cleared by reset
// - center off and mode_select_high set selects edge PWM
// - otherwise mode_select_low picks capture (0) or compare (1)
// - edge_level_select means edge, match action or PWM polarity by mode
// - edge_level_select 00 releases the pin; channel still works by software
// - capture on rising for 01, falling for 10, either for 11
// - compare match: 00 nothing, 01 toggle, 10 low, 11 high
// - PWM 10 gives high-true pulses, X1 low-true pulses
`timescale 1ns/10ps
module tccr_top #(
  parameter int NCH = 2
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [tccr_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       fixedClkTick,
  input  wire logic                       extClkIn,
  input  wire logic                       debugMode,
  input  wire logic [NCH-1:0]             chanPinIn,
  output logic      [NCH-1:0]             chanPinOut,
  output logic      [NCH-1:0]             chanPinOe,
  output logic      [NCH-1:0]             chanIrq,
  output logic                            overflowIrq
);
  // address map leaves room for eight channels
  if (NCH < 1 || NCH > 8) begin : g_chk
    $error("tccr_top: NCH must be 1 to 8");
  end

  logic        acc, wr, rd;
  logic        hitTsc, hitCntH, hitCntL, hitModH, hitModL;
  logic        wrTsc, wrCnt, rdCntH, rdCntL;
  logic [7:0]  rdByte;
  logic [15:0] cnt, modVal, cntBuf, term;
  logic        cntLatched, bufWaitHigh, countDown;
  logic        overflow_flag, tofArmed, tofIe, cpwm, tofSet, atTerm, ovfEvt;
  logic [1:0]  clkSel;
  logic [2:0]  psSel;
  logic [6:0]  psCnt, psMask;
  logic        srcTick, tick, extPrev;
  logic        modPending, modWaitHigh;

  logic [NCH-1:0] chScHit, chVhHit, chVlHit;
  logic [NCH-1:0] chFlag, chArmed, chIe, chCapEvt, chMatchEvt, chEvt;
  logic [1:0]     chMs  [NCH];
  logic [1:0]     chEls [NCH];
  logic [15:0]    chVal [NCH];
  logic [NCH-1:0] pinPrev;
  tccr_pkg::tccr_mode_t chMode [NCH];

  // a new request is taken only while ack is low, so each access acts once
  assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = acc & wb_we_i & wb_sel_i[0];
  assign rd      = acc & ~wb_we_i;
  assign hitTsc  = wb_adr_i == tccr_pkg::OFF_TSC;
  assign hitCntH = wb_adr_i == tccr_pkg::OFF_CNTH;
  assign hitCntL = wb_adr_i == tccr_pkg::OFF_CNTL;
  assign hitModH = wb_adr_i == tccr_pkg::OFF_MODH;
  assign hitModL = wb_adr_i == tccr_pkg::OFF_MODL;
  assign wrTsc   = wr & hitTsc;
  assign wrCnt   = wr & (hitCntH | hitCntL);
  assign rdCntH  = rd & hitCntH;
  assign rdCntL  = rd & hitCntL;

  always_comb begin
    rdByte = 8'h00;
    if (hitTsc) begin
      rdByte = {overflow_flag, tofIe, cpwm, clkSel, psSel};
    end
    if (hitCntH) begin
      rdByte = cntLatched ? cntBuf[15:8] : cnt[15:8];
    end
    if (hitCntL) begin
      rdByte = cntLatched ? cntBuf[7:0] : cnt[7:0];
    end
    if (hitModH) begin
      rdByte = modVal[15:8];
    end
    if (hitModL) begin
      rdByte = modVal[7:0];
    end
    for (int i = 0; i < NCH; i++) begin
      if (chScHit[i]) begin
        rdByte = {chFlag[i], chIe[i], chMs[i], chEls[i], 2'b00};
      end
      if (chVhHit[i]) begin
        rdByte = chVal[i][15:8];
      end
      if (chVlHit[i]) begin
        rdByte = chVal[i][7:0];
      end
    end
  end

  // one wait state; unmapped addresses answer with zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        wb_dat_o <= {24'h00_0000, rdByte};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tofIe  <= 1'b0;
      cpwm   <= 1'b0;
      clkSel <= tccr_pkg::CLK_OFF;
      psSel  <= 3'h0;
    end else if (wrTsc) begin
      tofIe  <= wb_dat_i[tccr_pkg::TSC_TOIE];
      cpwm   <= wb_dat_i[tccr_pkg::TSC_CPWM];
      clkSel <= wb_dat_i[tccr_pkg::TSC_CLK_LSB +: 2];
      psSel  <= wb_dat_i[tccr_pkg::TSC_PS_LSB +: 3];
    end
  end

  always_comb begin
    unique case (clkSel)
      tccr_pkg::CLK_OFF:   srcTick = 1'b0;
      tccr_pkg::CLK_BUS:   srcTick = 1'b1;
      tccr_pkg::CLK_FIXED: srcTick = fixedClkTick;
      tccr_pkg::CLK_EXT:   srcTick = extClkIn & ~extPrev;
    endcase
  end

  assign psMask = 7'((8'h01 << psSel) - 8'h01);
  assign tick   = srcTick & ~debugMode & ((psCnt & psMask) == psMask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psCnt   <= tccr_pkg::PS_RST;
      extPrev <= 1'b0;
    end else begin
      extPrev <= extClkIn;
      if (srcTick && !debugMode) begin
        psCnt <= psCnt + 7'h01;
      end
    end
  end

  // a zero modulo means the full range
  assign term   = (modVal == tccr_pkg::MOD_RST) ? tccr_pkg::CNT_FULL : modVal;
  assign atTerm = cnt >= term;
  assign ovfEvt = tick & atTerm & ~(cpwm & countDown);
  assign tofSet = ovfEvt & ~modPending;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt       <= tccr_pkg::CNT_RST;
      countDown <= 1'b0;
    end else if (wrCnt) begin
      cnt       <= tccr_pkg::CNT_RST;
      countDown <= 1'b0;
    end else if (tick) begin
      if (!cpwm) begin
        countDown <= 1'b0;
        cnt       <= atTerm ? tccr_pkg::CNT_RST : cnt + 16'h0001;
      end else if (countDown) begin
        if (cnt == tccr_pkg::CNT_RST) begin
          countDown <= 1'b0;
          cnt       <= 16'h0001;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end else if (atTerm) begin
        countDown <= 1'b1;
        cnt       <= cnt - 16'h0001;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // snapshot state stays put in debug, even across reads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cntLatched  <= 1'b0;
      bufWaitHigh <= 1'b0;
      cntBuf      <= tccr_pkg::CNT_RST;
    end else if (!debugMode) begin
      if (wrCnt || wrTsc) begin
        cntLatched <= 1'b0;
      end else if (!cntLatched && (rdCntH || rdCntL)) begin
        cntLatched  <= 1'b1;
        cntBuf      <= cnt;
        bufWaitHigh <= rdCntL;
      end else if (cntLatched && (bufWaitHigh ? rdCntH : rdCntL)) begin
        cntLatched <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modVal      <= tccr_pkg::MOD_RST;
      modPending  <= 1'b0;
      modWaitHigh <= 1'b0;
    end else if (wr && (hitModH || hitModL)) begin
      if (hitModH) begin
        modVal[15:8] <= wb_dat_i[7:0];
      end else begin
        modVal[7:0] <= wb_dat_i[7:0];
      end
      if (modPending && (modWaitHigh == hitModH)) begin
        modPending <= 1'b0;
      end else begin
        modPending  <= 1'b1;
        modWaitHigh <= hitModL;
      end
    end
  end

  // a set in the same cycle as the clearing write wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag      <= 1'b0;
      tofArmed <= 1'b0;
    end else begin
      if (tofSet) begin
        overflow_flag      <= 1'b1;
        tofArmed <= 1'b0;
      end else if (wrTsc) begin
        if (tofArmed && !wb_dat_i[tccr_pkg::TSC_TOF]) begin
          overflow_flag <= 1'b0;
        end
        tofArmed <= 1'b0;
      end else if (rd && hitTsc && overflow_flag) begin
        tofArmed <= 1'b1;
      end
    end
  end
  assign overflowIrq = overflow_flag & tofIe;

  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam logic [7:0] CH_ADR = 8'(tccr_pkg::CH_BASE + n * tccr_pkg::CH_STRIDE);
    logic rise, fall, highTrue;

    assign chScHit[n] = wb_adr_i == 8'(CH_ADR + tccr_pkg::CH_SC);
    assign chVhHit[n] = wb_adr_i == 8'(CH_ADR + tccr_pkg::CH_VH);
    assign chVlHit[n] = wb_adr_i == 8'(CH_ADR + tccr_pkg::CH_VL);

    always_comb begin
      if (cpwm) begin
        chMode[n] = tccr_pkg::MODE_CENTER_PWM;
      end else if (chMs[n][1]) begin
        chMode[n] = tccr_pkg::MODE_EDGE_PWM;
      end else if (chMs[n][0]) begin
        chMode[n] = tccr_pkg::MODE_COMPARE;
      end else begin
        chMode[n] = tccr_pkg::MODE_CAPTURE;
      end
    end

    assign rise     = chanPinIn[n] & ~pinPrev[n];
    assign fall     = ~chanPinIn[n] & pinPrev[n];
    assign highTrue = chEls[n] == tccr_pkg::ELS_10;
    assign chCapEvt[n] = (chMode[n] == tccr_pkg::MODE_CAPTURE) &
                         ((chEls[n] == tccr_pkg::ELS_01 & rise) |
                          (chEls[n] == tccr_pkg::ELS_10 & fall) |
                          (chEls[n] == tccr_pkg::ELS_11 & (rise | fall)));
    // center mode matches in both directions, hence both pulse edges
    assign chMatchEvt[n] = (chMode[n] != tccr_pkg::MODE_CAPTURE) & tick &
                           (cnt == chVal[n]);
    assign chEvt[n] = chCapEvt[n] | chMatchEvt[n];

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chIe[n]  <= 1'b0;
        chMs[n]  <= 2'b00;
        chEls[n] <= tccr_pkg::ELS_NONE;
      end else if (wr && chScHit[n]) begin
        chIe[n]  <= wb_dat_i[tccr_pkg::SC_IE];
        chMs[n]  <= {wb_dat_i[tccr_pkg::SC_MSH], wb_dat_i[tccr_pkg::SC_MSL]};
        chEls[n] <= wb_dat_i[tccr_pkg::SC_ELS_LSB +: 2];
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chFlag[n]  <= 1'b0;
        chArmed[n] <= 1'b0;
      end else begin
        if (chEvt[n]) begin
          chFlag[n]  <= 1'b1;
          chArmed[n] <= 1'b0;
        end else if (wr && chScHit[n]) begin
          if (chArmed[n] && !wb_dat_i[tccr_pkg::SC_FLAG]) begin
            chFlag[n] <= 1'b0;
          end
          chArmed[n] <= 1'b0;
        end else if (rd && chScHit[n] && chFlag[n]) begin
          chArmed[n] <= 1'b1;
        end
      end
    end

    // captures overwrite the value, so a same-cycle write is dropped
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chVal[n] <= tccr_pkg::VAL_RST;
      end else if (chCapEvt[n]) begin
        chVal[n] <= cnt;
      end else if (wr && chVhHit[n]) begin
        chVal[n][15:8] <= wb_dat_i[7:0];
      end else if (wr && chVlHit[n]) begin
        chVal[n][7:0] <= wb_dat_i[7:0];
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pinPrev[n]    <= 1'b0;
        chanPinOut[n] <= 1'b0;
      end else begin
        pinPrev[n] <= chanPinIn[n];
        unique case (chMode[n])
          tccr_pkg::MODE_CAPTURE: begin
          end
          tccr_pkg::MODE_COMPARE: begin
            if (chMatchEvt[n]) begin
              unique case (chEls[n])
                tccr_pkg::ELS_NONE: begin
                end
                tccr_pkg::ELS_01: chanPinOut[n] <= ~chanPinOut[n];
                tccr_pkg::ELS_10: chanPinOut[n] <= 1'b0;
                tccr_pkg::ELS_11: chanPinOut[n] <= 1'b1;
              endcase
            end
          end
          tccr_pkg::MODE_EDGE_PWM: begin
            if (chMatchEvt[n]) begin
              chanPinOut[n] <= ~highTrue;
            end else if (ovfEvt) begin
              chanPinOut[n] <= highTrue;
            end
          end
          tccr_pkg::MODE_CENTER_PWM: begin
            if (chMatchEvt[n]) begin
              chanPinOut[n] <= countDown ? highTrue : ~highTrue;
            end
          end
        endcase
      end
    end

    assign chanPinOe[n] = (chEls[n] != tccr_pkg::ELS_NONE) &
                          (chMode[n] != tccr_pkg::MODE_CAPTURE);
    assign chanIrq[n]   = chFlag[n] & chIe[n];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_clock_off_idle: assert property (
    clkSel == tccr_pkg::CLK_OFF |-> !tick ##1 $stable(psCnt))
    else $error("tick without a clock source");
  chk_prescale_two: assert property (
    tick && clkSel == tccr_pkg::CLK_BUS && psSel == 3'h1 && !wrTsc |=> !tick)
    else $error("divide by two ticked twice in a row");
  chk_snapshot_take: assert property (
    rdCntL && !cntLatched && !debugMode && !wrCnt && !wrTsc
      |=> cntLatched && cntBuf == $past(cnt) ##1 wb_dat_o[7:0] == $past(cntBuf[7:0], 1))
    else $error("counter snapshot not taken");
  chk_snapshot_drop: assert property (
    (wrTsc || wrCnt) && !debugMode |=> !cntLatched)
    else $error("snapshot survived a write");
  chk_debug_freeze: assert property (
    debugMode && !wrCnt |=> cnt == $past(cnt) && cntLatched == $past(cntLatched))
    else $error("counter moved in debug");
  chk_up_wrap: assert property (
    tick && !cpwm && atTerm && !wrCnt && !modPending |=> cnt == 16'h0000 && overflow_flag)
    else $error("no wrap or flag at modulo");
  chk_mod_inhibit: assert property (
    $rose(overflow_flag) |-> !$past(modPending))
    else $error("overflow flag set with modulo half written");
  chk_event_wins: assert property (
    chEvt[0] |=> chFlag[0] [*1] ##1 1'b1)
    else $error("channel event lost");
  chk_flag_clear: assert property (
    $fell(chFlag[0]) |-> $past(chArmed[0] && wr && chScHit[0] && !wb_dat_i[7]))
    else $error("channel flag cleared without the sequence");
  chk_irq_gate: assert property (
    chEvt[0] && chIe[0] && !(wr && chScHit[0]) |=> chanIrq[0])
    else $error("channel interrupt missing");
  chk_pin_release: assert property (
    chEls[0] == tccr_pkg::ELS_NONE |-> !chanPinOe[0] ##1 (chEls[0] != 2'h0 || !chanPinOe[0]))
    else $error("pin driven with edge_level_select 00");
  chk_capture_edge: assert property (
    chMode[0] == tccr_pkg::MODE_CAPTURE && chEls[0] == tccr_pkg::ELS_01 && rd == 1'b0
      && g_ch[0].rise |=> chFlag[0] && chVal[0] == $past(cnt))
    else $error("rising edge not captured");

  cov_overflow: cover property (!overflow_flag ##1 overflow_flag);
  cov_flag_cleared: cover property (chArmed[0] ##1 $fell(chFlag[0]));
  cov_center_turn: cover property (cpwm && !countDown ##1 countDown);
  cov_snapshot_pair: cover property (cntLatched ##[1:20] !cntLatched);
endmodule // tccr_top

// file: tccr_pin_model.sv
/*
  tccr_pin_model: what stands outside the timer: the channel pins with an
  outside driver, the fixed-clock tick source and the external clock input.
  Assumes the bench drives pinDrive by non-blocking assignment after clk rises.
*/
`timescale 1ns/10ps
module tccr_pin_model #(
  parameter int NCH = 2
) (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic [NCH-1:0] chanPinOut,
  input  wire logic [NCH-1:0] chanPinOe,
  input  wire logic [NCH-1:0] pinDrive,
  output logic      [NCH-1:0] chanPinIn,
  output logic                extClkIn,
  output logic                fixedClkTick
);
  logic [3:0] div;

  // the design sees its own drive while enabled, the outside driver otherwise
  assign chanPinIn = (chanPinOe & chanPinOut) | (~chanPinOe & pinDrive);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      div <= 4'h0;
    else
      div <= div + 4'h1;
  end

  // period of 16 cycles keeps the external clock under a quarter of the bus rate
  assign extClkIn     = div[3];
  assign fixedClkTick = (div[2:0] == 3'h7);
endmodule // tccr_pin_model

// file: tccr_top_bench.sv
/*
  tccr_top_bench: self-checking bench for the timer over classic Wishbone.
  Assumes the package offsets and a registered one-cycle ack.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tccr_top_bench;
  localparam int         NCH  = 2;
  localparam logic [7:0] SC0  = tccr_pkg::CH_BASE + tccr_pkg::CH_SC;
  localparam logic [7:0] VL0  = tccr_pkg::CH_BASE + tccr_pkg::CH_VL;
  localparam logic [7:0] VH0  = tccr_pkg::CH_BASE + tccr_pkg::CH_VH;
  logic             clk, reset_n, wbCyc, wbStb, wbWe, wbAck, debugMode;
  logic             extClkIn, fixedClkTick, overflowIrq;
  logic [7:0]       wbAdr;
  logic [3:0]       wbSel;
  logic [31:0]      wbDat, wbDatO;
  logic [NCH-1:0]   pinIn, pinOut, pinOe, chanIrq, pinDrive;
  int               errorCnt, samplesChecked;

  tccr_top #(.NCH(NCH)) tccr_top_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .fixedClkTick(fixedClkTick), .extClkIn(extClkIn),
    .debugMode(debugMode), .chanPinIn(pinIn), .chanPinOut(pinOut), .chanPinOe(pinOe),
    .chanIrq(chanIrq), .overflowIrq(overflowIrq));
  tccr_pin_model #(.NCH(NCH)) tccr_pin_model_i (.clk(clk), .reset_n(reset_n),
    .chanPinOut(pinOut), .chanPinOe(pinOe), .pinDrive(pinDrive), .chanPinIn(pinIn),
    .extClkIn(extClkIn), .fixedClkTick(fixedClkTick));

  task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [7:0] d,
                       output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbDat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) errorCnt++;
    q = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] q;
    wbAcc(1'b1, adr, d, q);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [7:0] q);
    wbAcc(1'b0, adr, 8'h00, q);
  endtask

  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic testReset;
    logic [7:0] q;
    rd(tccr_pkg::OFF_CNTH, q); `CHK(q, 8'h00)
    rd(tccr_pkg::OFF_CNTL, q); `CHK(q, 8'h00)
    rd(tccr_pkg::OFF_MODH, q); `CHK(q, 8'h00)
    rd(tccr_pkg::OFF_MODL, q); `CHK(q, 8'h00)
    rd(SC0, q);                `CHK(q, 8'h00)
    wr(tccr_pkg::OFF_CNTH, 8'hAB);
    repeat (50) @(posedge clk);
    rd(tccr_pkg::OFF_CNTH, q); `CHK(q, 8'h00)
    $display("test reset done");
  endtask

  task automatic testClock;
    logic [1:0] src [5] = '{tccr_pkg::CLK_BUS, tccr_pkg::CLK_BUS, tccr_pkg::CLK_FIXED,
                            tccr_pkg::CLK_EXT, tccr_pkg::CLK_OFF};
    logic [2:0] ps [5]  = '{3'h3, 3'h1, 3'h0, 3'h0, 3'h0};
    int         ex [5]  = '{100, 401, 100, 50, 0};
    logic [7:0] q, h;
    // channel 0 stays released while the external clock is in use
    for (int i = 0; i < 5; i++) begin
      wr(tccr_pkg::OFF_TSC, {3'h0, src[i], ps[i]});
      wr(tccr_pkg::OFF_CNTL, 8'h00);
      repeat (800) @(posedge clk);
      rd(tccr_pkg::OFF_CNTL, q);
      rd(tccr_pkg::OFF_CNTH, h); `CHK(h, 8'(ex[i] >> 8))
      `CHK(int'({h, q}) >= ex[i] - 3 && int'({h, q}) <= ex[i] + 3, 1'b1)
    end
    $display("test clock done");
  endtask

  task automatic testCoherent;
    logic [7:0] q;
    wr(tccr_pkg::OFF_TSC, 8'h08);
    wr(tccr_pkg::OFF_CNTL, 8'h00);
    rd(tccr_pkg::OFF_CNTL, q); `CHK(q <= 8'h08, 1'b1)
    repeat (600) @(posedge clk);
    rd(tccr_pkg::OFF_CNTH, q); `CHK(q, 8'h00)
    rd(tccr_pkg::OFF_CNTH, q); `CHK(q, 8'h02)
    rd(tccr_pkg::OFF_CNTL, q);
    wr(tccr_pkg::OFF_CNTH, 8'h00);
    rd(tccr_pkg::OFF_CNTL, q);
    repeat (600) @(posedge clk);
    wr(tccr_pkg::OFF_TSC, 8'h08);
    rd(tccr_pkg::OFF_CNTH, q); `CHK(q, 8'h02)
    rd(tccr_pkg::OFF_CNTL, q);
    $display("test coherent done");
  endtask

  task automatic testOverflow;
    logic [7:0] a, b, c;
    wr(tccr_pkg::OFF_CNTL, 8'h00);
    wr(tccr_pkg::OFF_MODH, 8'h00);
    wr(tccr_pkg::OFF_MODL, 8'h10);
    repeat (40) @(posedge clk);
    debugMode <= 1'b1;
    rd(tccr_pkg::OFF_CNTL, a);
    rd(tccr_pkg::OFF_CNTH, b); `CHK(b, 8'h00)
    repeat (50) @(posedge clk);
    rd(tccr_pkg::OFF_CNTL, c); `CHK(c, a)
    `CHK(a <= 8'h10, 1'b1)
    debugMode <= 1'b0;
    rd(tccr_pkg::OFF_TSC, a); `CHK(a[7], 1'b1)
    wr(tccr_pkg::OFF_MODH, 8'h00);
    rd(tccr_pkg::OFF_TSC, a);
    wr(tccr_pkg::OFF_TSC, 8'h08);
    repeat (100) @(posedge clk);
    rd(tccr_pkg::OFF_TSC, a); `CHK(a[7], 1'b0)
    wr(tccr_pkg::OFF_MODL, 8'h10);
    repeat (40) @(posedge clk);
    rd(tccr_pkg::OFF_TSC, a); `CHK(a[7], 1'b1)
    // bit 7 written as 1 so the armed clear does not fire
    wr(tccr_pkg::OFF_TSC, 8'hC8);
    #1;
    `CHK(overflowIrq, 1'b1)
    $display("test overflow done");
  endtask

  task automatic testCompare;
    logic [7:0] q;
    logic       a;
    wr(VH0, 8'h00);
    wr(VL0, 8'h05);
    for (int e = 0; e < 4; e++) begin
      wr(SC0, 8'h50 | 8'(e << 2));
      repeat (40) @(posedge clk);
      #1;
      `CHK(pinOe[0], logic'(e != 0))
      a = pinOut[0];
      if (e == 2) `CHK(a, 1'b0)
      if (e == 3) `CHK(a, 1'b1)
      repeat (17) @(posedge clk);
      #1;
      if (e == 1) `CHK(pinOut[0], ~a)
    end
    wr(VL0, 8'h80);
    #1;
    `CHK(chanIrq[0], 1'b1)
    wr(SC0, 8'hDC);
    rd(SC0, q); `CHK(q[7:6], 2'h3)
    wr(SC0, 8'h5C);
    rd(SC0, q); `CHK(q[7], 1'b0)
    #1;
    `CHK(chanIrq[0], 1'b0)
    `CHK({chanIrq[1], pinOe[1], pinOut[1]}, 3'h0)
    $display("test compare done");
  endtask

  task automatic testPwm;
    int hi;
    wr(VL0, 8'h04);
    for (int e = 2; e > 0; e--) begin
      wr(SC0, 8'h20 | 8'(e << 2));
      // one full period first, so the pin starts from its steady pattern
      repeat (17) @(posedge clk);
      hi = 0;
      repeat (170) begin
        @(posedge clk);
        #1;
        hi += int'(pinOut[0]);
      end
      `CHK(hi, e == 2 ? 50 : 120)
    end
    // center mode: period of 32 counts, high-true pulse twice the value wide
    wr(tccr_pkg::OFF_TSC, 8'h28);
    wr(SC0, 8'h08);
    repeat (32) @(posedge clk);
    hi = 0;
    repeat (160) begin
      @(posedge clk);
      #1;
      hi += int'(pinOut[0]);
    end
    `CHK(hi, 40)
    wr(tccr_pkg::OFF_TSC, 8'h08);
    $display("test pwm done");
  endtask

  task automatic testCapture;
    logic [7:0] q;
    logic [1:0] els;
    for (int e = 1; e < 4; e++) begin
      els = 2'(e);
      wr(SC0, {4'h0, els, 2'h0});
      rd(SC0, q);
      wr(SC0, {4'h0, els, 2'h0});
      pinDrive[0] <= 1'b1;
      repeat (4) @(posedge clk);
      rd(SC0, q); `CHK(q[7], els[0])
      wr(SC0, {4'h0, els, 2'h0});
      pinDrive[0] <= 1'b0;
      repeat (4) @(posedge clk);
      rd(SC0, q); `CHK(q[7], els[1])
      wr(SC0, {4'h0, els, 2'h0});
    end
    $display("test capture done");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errorCnt++;
    tallyAndFinish();
  end

  initial begin
    errorCnt = 0;
    samplesChecked = 0;
    reset_n = 1'b0;
    {wbCyc, wbStb, wbWe, debugMode} = 4'h0;
    wbAdr = 8'h00;
    wbSel = 4'h1;
    wbDat = 32'h00000000;
    pinDrive = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    testReset();
    testClock();
    testCoherent();
    testOverflow();
    testCompare();
    testPwm();
    testCapture();
    tallyAndFinish();
  end
endmodule // tccr_top_bench
